/* urx_error_irq.sv */
// receive path with error flags, interrupt pulse, address detect and rx wake-up
// What this block does
// - buffer holds two characters while a third shifts in; late reads overrun
// - on overrun set flag, keep buffer, drop shifter word, interrupt if enabled
// - overrun flag clears after status access then data read, or when the receiver is disabled
// - noisy frame still stored; noise flag rises with data-available, no own interrupt
// - noise flag clears after status read then data read
// - framing error when first stop bit samples low; second stop unchecked
// - framed-bad character still stored; reset clears framing flag
// - parity error flagged when enabled and wrong; word stored; reset clears
// - each interrupt request is an active-low pulse
// - sources: tx empty, tx idle, rx available, overrun, address, wake-up
// - tx sources have own enables; rx sources share one enable
// - flags are read-only and clear by defined access sequences; overrun also clears when the receiver is disabled
// - address detect: data-available interrupt only when top received bit is high
// - without address detect every data-available set interrupts
// - stopped clock pauses reception, resumes when clock returns
// - idle or sleep leaves all registers unchanged
// - clock off with wake, enable, rx enable, rx irq: falling rx wakes
// - rx data ignored during startup delay; wake interrupt after it
// - without global and serial irq enables wake-up gives no interrupt
// - data-available flag clears only after status access then data read
// - each bit level is a majority vote of three rx samples
`default_nettype none
module urx_error_irq #(
   parameter int STARTUP = urx_pkg::STARTUP_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial line and transmitter status
   input wire logic rxLine,
   input wire logic txEmpty,
   input wire logic txIdle,
   // processor side
   output logic irqPulse_n,
   output logic wakeRequest
);
   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_WAITHIGH} urx_state_t;
   urx_state_t state;
   logic [7:0] ctrlOne, ctrlTwo, divider, power;
   logic [7:0] baudCount;
   logic [3:0] phase, bitCount;
   logic [8:0] shifter;
   logic parityAcc, noiseSeen, parBit;
   logic voted, noisy, sampleTick, clkRun, rxEnabled;
   logic push, full, empty, pop;
   logic [11:0] pushData, headData;
   logic overrun, statusArmed, prevRx, prevAvail;
   logic [15:0] startCount;
   logic waking, wakeDone;
   logic rxEvent, ovEvent, irqAny, prevTxEmpty, prevTxIdle;
   logic apbWrite, apbRead, dataRead, statusRead;
   logic frameEnd;
   logic [7:0] statusByte;

   // the startup counter is sixteen bits wide
   if (STARTUP < 1 || STARTUP > 65535) begin : g_startup_check
      $error("STARTUP must lie between 1 and 65535");
   end

   assign apbWrite = psel && penable && pwrite;
   assign apbRead = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && (paddr > urx_pkg::POWER_OFS || paddr[1:0] != 2'b00);
   assign statusRead = psel && penable && paddr == urx_pkg::STATUS_OFS;
   assign dataRead = apbRead && paddr == urx_pkg::DATA_OFS;
   assign clkRun = !power[urx_pkg::PW_CLK_OFF] && !waking;
   assign rxEnabled = ctrlOne[urx_pkg::C1_PORT_EN] && ctrlTwo[urx_pkg::C2_RX_EN];

   // control registers hold through idle and sleep
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ctrlOne <= urx_pkg::CTRL_RESET;
      end else if (apbWrite && paddr == urx_pkg::CTRL1_OFS) begin
         ctrlOne <= pwdata[7:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ctrlTwo <= urx_pkg::CTRL_RESET;
      end else if (apbWrite && paddr == urx_pkg::CTRL2_OFS) begin
         ctrlTwo <= pwdata[7:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         divider <= urx_pkg::DIVIDER_RESET;
      end else if (apbWrite && paddr == urx_pkg::DIVIDER_OFS) begin
         divider <= pwdata[7:0];
      end
   end

   // power register; clock-off is cleared by hardware when the startup delay ends
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         power <= urx_pkg::CTRL_RESET;
      end else if (apbWrite && paddr == urx_pkg::POWER_OFS) begin
         power <= pwdata[7:0];
      end else if (wakeDone) begin
         power[urx_pkg::PW_CLK_OFF] <= 1'b0;
      end
   end

   // oversampling tick, frozen while the clock is off
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         baudCount <= 8'h00;
      end else if (clkRun) begin
         baudCount <= (baudCount >= divider) ? 8'h00 : baudCount + 8'h01;
      end
   end
   assign sampleTick = clkRun && baudCount >= divider;

   urx_sampler sampler (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .sampleTick(sampleTick),
      .rxLine(rxLine),
      .voted(voted),
      .noisy(noisy)
   );

   // receive frame state machine
   assign parBit = ctrlOne[urx_pkg::C1_PAR_ODD] ^ parityAcc;
   always_ff @(posedge ref_clk) begin
      if (!reset_n || !rxEnabled) begin
         state <= RX_IDLE;
         phase <= 4'h0;
         bitCount <= 4'h0;
         shifter <= 9'h000;
         parityAcc <= 1'b0;
      end else begin
         if (sampleTick) begin
            phase <= phase + 4'h1;
            case (state)
               RX_IDLE: begin
                  phase <= 4'h0;
                  if (!voted) state <= RX_START;
               end
               RX_START: if (phase == 4'(urx_pkg::OVERSAMPLE / 2)) begin
                  phase <= 4'h0;
                  bitCount <= 4'h0;
                  parityAcc <= 1'b0;
                  state <= voted ? RX_IDLE : RX_DATA;
               end
               RX_DATA: if (phase == 4'(urx_pkg::OVERSAMPLE - 1)) begin
                  shifter <= ctrlOne[urx_pkg::C1_NINE] ? {voted, shifter[8:1]} : {1'b0, voted, shifter[7:1]};
                  parityAcc <= parityAcc ^ voted;
                  bitCount <= bitCount + 4'h1;
                  if (bitCount == (ctrlOne[urx_pkg::C1_NINE] ? 4'h8 : 4'h7)) begin
                     state <= ctrlOne[urx_pkg::C1_PAR_EN] ? RX_PARITY : RX_STOP;
                  end
               end
               RX_PARITY: if (phase == 4'(urx_pkg::OVERSAMPLE - 1)) begin
                  parityAcc <= parityAcc ^ voted;
                  state <= RX_STOP;
               end
               RX_STOP: if (phase == 4'(urx_pkg::OVERSAMPLE - 1)) begin
                  // only the first stop bit is checked
                  state <= voted ? RX_IDLE : RX_WAITHIGH;
               end
               RX_WAITHIGH: if (voted) state <= RX_IDLE;
               default: state <= RX_IDLE;
            endcase
         end
      end
   end

   assign frameEnd = sampleTick && state == RX_STOP && phase == 4'(urx_pkg::OVERSAMPLE - 1);

   // noise is looked at wherever a bit level is taken
   always_ff @(posedge ref_clk) begin
      if (!reset_n || !rxEnabled) begin
         noiseSeen <= 1'b0;
      end else if (sampleTick) begin
         if (state == RX_IDLE) begin
            noiseSeen <= 1'b0;
         end else if (phase == (state == RX_START ? 4'(urx_pkg::OVERSAMPLE / 2) : 4'(urx_pkg::OVERSAMPLE - 1))) begin
            noiseSeen <= noiseSeen | noisy;
         end
      end
   end

   // a finished frame goes to the buffer with its error bits unless the buffer is full
   always_ff @(posedge ref_clk) begin
      if (!reset_n || !rxEnabled) begin
         push <= 1'b0;
         pushData <= 12'h000;
      end else begin
         push <= frameEnd && !full;
         if (frameEnd && !full) begin
            pushData <= {noiseSeen | noisy, !voted, ctrlOne[urx_pkg::C1_PAR_EN] && (parBit != 1'b0), shifter};
         end
      end
   end

   // overrun: a frame ending against a full buffer sets it, the access sequence clears it
   always_ff @(posedge ref_clk) begin
      if (!reset_n || !rxEnabled) begin
         overrun <= 1'b0;
      end else if (ovEvent) begin
         overrun <= 1'b1;
      end else if (dataRead && statusArmed) begin
         overrun <= 1'b0;
      end
   end

   urx_fifo #(.WIDTH(12), .DEPTH(urx_pkg::FIFO_DEPTH)) fifo (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .push(push),
      .pushData(pushData),
      .full(full),
      .pop(pop),
      .headData(headData),
      .empty(empty)
   );

   // a status access arms the next data read to pop and clear
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         statusArmed <= 1'b0;
      end else if (statusRead) begin
         statusArmed <= 1'b1;
      end else if (dataRead) begin
         statusArmed <= 1'b0;
      end
   end
   assign pop = dataRead && statusArmed;

   // status byte; noise, framing and parity bits describe the entry at the head of the buffer, overrun is a separate flag
   always_comb begin
      statusByte = 8'h00;
      statusByte[urx_pkg::ST_TXEMPTY] = txEmpty;
      statusByte[urx_pkg::ST_TXIDLE] = txIdle;
      statusByte[urx_pkg::ST_RXAVAIL] = !empty;
      statusByte[urx_pkg::ST_RXIDLE] = state == RX_IDLE;
      statusByte[urx_pkg::ST_OVERRUN] = overrun;
      statusByte[urx_pkg::ST_NOISE] = !empty && headData[11];
      statusByte[urx_pkg::ST_FRAMING] = !empty && headData[10];
      statusByte[urx_pkg::ST_PARITY] = !empty && headData[9];
   end

   // read data register
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            urx_pkg::STATUS_OFS: prdata <= {24'h000000, statusByte};
            urx_pkg::DATA_OFS: prdata <= {23'h000000, headData[8:0]};
            urx_pkg::CTRL1_OFS: prdata <= {24'h000000, ctrlOne};
            urx_pkg::CTRL2_OFS: prdata <= {24'h000000, ctrlTwo};
            urx_pkg::DIVIDER_OFS: prdata <= {24'h000000, divider};
            urx_pkg::POWER_OFS: prdata <= {24'h000000, power};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // previous rx level for the falling-edge detector, idle high
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         prevRx <= 1'b1;
      end else begin
         prevRx <= rxLine;
      end
   end

   // wake-up: falling rx while clock off, then startup delay
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         waking <= 1'b0;
         startCount <= 16'h0000;
      end else begin
         if (power[urx_pkg::PW_CLK_OFF] && !waking && ctrlTwo[urx_pkg::C2_WAKE] && rxEnabled
             && ctrlTwo[urx_pkg::C2_RX_IRQ] && prevRx && !rxLine) begin
            waking <= 1'b1;
            startCount <= 16'(STARTUP);
         end else if (waking) begin
            startCount <= startCount - 16'h0001;
            if (startCount == 16'h0001) begin
               waking <= 1'b0;
            end
         end
      end
   end

   // one-cycle strobe when the startup delay runs out
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         wakeDone <= 1'b0;
      end else begin
         wakeDone <= waking && startCount == 16'h0001;
      end
   end
   assign wakeRequest = waking;

   // a push is seen one cycle later as the data-available event
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         prevAvail <= 1'b0;
      end else begin
         prevAvail <= push;
      end
   end

   // transmitter status levels for rising-edge detection
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         prevTxEmpty <= 1'b0;
         prevTxIdle <= 1'b0;
      end else begin
         prevTxEmpty <= txEmpty;
         prevTxIdle <= txIdle;
      end
   end

   // one low cycle per event, only with both processor enables
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         irqPulse_n <= 1'b1;
      end else begin
         irqPulse_n <= !(irqAny && power[urx_pkg::PW_GLOBAL_IRQ] && power[urx_pkg::PW_SERIAL_IRQ]);
      end
   end
   // address detect qualifies the data-available source
   assign rxEvent = prevAvail && (!ctrlTwo[urx_pkg::C2_ADDR_DET] ||
      (ctrlOne[urx_pkg::C1_NINE] ? pushData[8] : pushData[7]));
   assign ovEvent = frameEnd && full;
   assign irqAny = (ctrlTwo[urx_pkg::C2_RX_IRQ] && (rxEvent || ovEvent))
      || (ctrlTwo[urx_pkg::C2_TXEMPTY_IRQ] && txEmpty && !prevTxEmpty)
      || (ctrlTwo[urx_pkg::C2_TXIDLE_IRQ] && txIdle && !prevTxIdle)
      || wakeDone;
endmodule // urx_error_irq
`default_nettype wire

/* urx_pkg.sv */
// package with register map, field positions and constants for the receive error block
`default_nettype none
package urx_pkg;
   // register byte offsets
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] DATA_OFS = 8'h04;
   localparam logic [7:0] CTRL1_OFS = 8'h08;
   localparam logic [7:0] CTRL2_OFS = 8'h0c;
   localparam logic [7:0] DIVIDER_OFS = 8'h10;
   localparam logic [7:0] POWER_OFS = 8'h14;
   // status fields
   localparam int ST_PARITY = 0;
   localparam int ST_FRAMING = 1;
   localparam int ST_NOISE = 2;
   localparam int ST_OVERRUN = 3;
   localparam int ST_RXIDLE = 4;
   localparam int ST_RXAVAIL = 5;
   localparam int ST_TXIDLE = 6;
   localparam int ST_TXEMPTY = 7;
   // control one fields
   localparam int C1_PORT_EN = 7;
   localparam int C1_NINE = 6;
   localparam int C1_PAR_EN = 5;
   localparam int C1_PAR_ODD = 4;
   localparam int C1_TWO_STOP = 3;
   // control two fields
   localparam int C2_RX_EN = 6;
   localparam int C2_ADDR_DET = 5;
   localparam int C2_WAKE = 3;
   localparam int C2_RX_IRQ = 2;
   localparam int C2_TXIDLE_IRQ = 1;
   localparam int C2_TXEMPTY_IRQ = 0;
   // power register fields
   localparam int PW_CLK_OFF = 0;
   localparam int PW_GLOBAL_IRQ = 1;
   localparam int PW_SERIAL_IRQ = 2;
   // reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] DIVIDER_RESET = 8'h00;
   // oversampling and timing
   localparam int OVERSAMPLE = 16;
   localparam int STARTUP_NS = 2000;
   localparam int CLK_NS = 100;
   localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int FIFO_DEPTH = 2;
endpackage
`default_nettype wire

/* urx_sampler.sv */
// majority vote over three samples of the receive line
`default_nettype none
module urx_sampler (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // line
   input wire logic sampleTick,
   input wire logic rxLine,
   output logic voted,
   output logic noisy
);
   logic [2:0] taps;
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         taps <= 3'h7;
      end else if (sampleTick) begin
         taps <= {taps[1:0], rxLine};
      end
   end
   // majority of three, disagreement marks noise
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         voted <= 1'b1;
         noisy <= 1'b0;
      end else begin
         voted <= (taps[0] & taps[1]) | (taps[1] & taps[2]) | (taps[0] & taps[2]);
         noisy <= !((taps == 3'h0) || (taps == 3'h7));
      end
   end
endmodule // urx_sampler
`default_nettype wire

/* urx_fifo.sv */
// two-entry receive holding buffer with word and error bits
`default_nettype none
module urx_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // write side
   input wire logic push,
   input wire logic [WIDTH-1:0] pushData,
   output logic full,
   // read side
   input wire logic pop,
   output logic [WIDTH-1:0] headData,
   output logic empty
);
   logic [WIDTH-1:0] store [DEPTH];
   logic [1:0] count;
   if (DEPTH != 2) begin : g_depth_check
      $error("urx_fifo supports depth 2 only");
   end
   assign full = (count == 2'd2);
   assign empty = (count == 2'd0);
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         count <= 2'd0;
      end else begin
         count <= count + {1'b0, push && !full} - {1'b0, pop && !empty};
      end
   end
   always_ff @(posedge ref_clk) begin
      if (pop && !empty) begin
         store[0] <= store[1];
         if (push && count == 2'd2) store[1] <= pushData;
         if (push && count == 2'd1) store[0] <= pushData;
      end else if (push && !full) begin
         store[count[0]] <= pushData;
      end
   end
   assign headData = store[0];
endmodule // urx_fifo
`default_nettype wire

/* urx_error_irq_assertions.sv */
// port checker for the receive error, interrupt and wake-up block
`default_nettype none
module urx_error_irq_assertions #(
   parameter int STARTUP = 3
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // line and processor side
   input wire logic rxLine,
   input wire logic txEmpty,
   input wire logic txIdle,
   input wire logic irqPulse_n,
   input wire logic wakeRequest
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic [15:0] wakeCnt;
   // counts cycles of the startup delay
   always_ff @(posedge ref_clk) begin
      if (!reset_n || !wakeRequest) wakeCnt <= 16'h0000;
      else wakeCnt <= wakeCnt + 16'h0001;
   end
   sequence seqAccess;
      psel && penable;
   endsequence
   sequence seqBadAddr;
      seqAccess ##0 (paddr > 8'h14 || paddr[1:0] != 2'b00);
   endsequence
   chk_irq_pulse_single: assert property (!irqPulse_n |=> irqPulse_n)
      else $error("interrupt pulse longer than one cycle");
   chk_wake_no_irq: assert property (wakeRequest |-> irqPulse_n)
      else $error("interrupt during startup delay");
   chk_wake_delay_len: assert property ($fell(wakeRequest) |-> wakeCnt == STARTUP[15:0])
      else $error("startup delay length wrong");
   chk_wake_rx_fall: assert property ($rose(wakeRequest) |-> !rxLine || !$past(rxLine))
      else $error("wake without falling rx line");
   chk_bad_addr_err: assert property (seqBadAddr |-> pslverr)
      else $error("unmapped access not refused");
   chk_good_addr_ok: assert property (seqAccess ##0 (paddr <= 8'h14 && paddr[1:0] == 2'b00) |-> !pslverr)
      else $error("mapped access refused");
   chk_zero_wait: assert property (seqAccess |-> pready)
      else $error("access not answered at once");
   chk_refused_read_zero: assert property (seqBadAddr ##0 !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
endmodule // urx_error_irq_assertions
`default_nettype wire

/* urx_line_model.sv */
// remote serial transmitter driving the receive line
`default_nettype none
module urx_line_model (
   // clock
   input wire logic ref_clk,
   // line
   output logic rxLine
);
   timeunit 1ns;
   timeprecision 1ns;
   initial rxLine = 1'b1;
   // bits lsb first, bit 0 is start; glitch inverts the line for one cycle
   task automatic send(input logic [11:0] bits, input int n, input int glitch);
      for (int i = 0; i < n; i++) begin
         for (int c = 0; c < 16; c++) begin
            @(posedge ref_clk);
            rxLine <= (i * 16 + c == glitch) ? ~bits[i] : bits[i];
         end
      end
      @(posedge ref_clk);
      rxLine <= 1'b1;
   endtask
endmodule // urx_line_model
`default_nettype wire

/* urx_error_irq_tb.sv */
// testbench for the receive error, interrupt and wake-up block
`default_nettype none
module urx_error_irq_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int STARTUP = 200;
   localparam logic [7:0] ST = urx_pkg::STATUS_OFS;
   localparam logic [7:0] DA = urx_pkg::DATA_OFS;
   localparam logic [7:0] C1 = urx_pkg::CTRL1_OFS;
   localparam logic [7:0] C2 = urx_pkg::CTRL2_OFS;
   localparam logic [7:0] PW = urx_pkg::POWER_OFS;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic txEmpty = 1'b0;
   logic txIdle = 1'b0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, rxLine, irqPulse_n, wakeRequest;
   int numErrors = 0;
   int cmpCount = 0;
   int irqs = 0;
   int wakes = 0;
   int c0;
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (irqPulse_n === 1'b0) irqs++;
      if (wakeRequest === 1'b1) wakes++;
   end
   urx_error_irq #(.STARTUP(STARTUP)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rxLine(rxLine), .txEmpty(txEmpty), .txIdle(txIdle), .irqPulse_n(irqPulse_n), .wakeRequest(wakeRequest));
   urx_line_model line (.ref_clk(ref_clk), .rxLine(rxLine));
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
         numErrors++;
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd & m, exp);
   endtask
   task automatic send(input logic [7:0] d, input logic stop, input int glitch);
      line.send({2'b11, stop, d, 1'b0}, 10, glitch);
      repeat (30) @(posedge ref_clk);
   endtask
   task automatic clr;
      apb(1'b0, ST, 32'h0);
      apb(1'b0, DA, 32'h0);
   endtask
   task automatic pulseTx(input logic idle);
      repeat (2) @(posedge ref_clk);
      if (idle) txIdle <= 1'b1;
      else txEmpty <= 1'b1;
      repeat (5) @(posedge ref_clk);
   endtask
   task automatic testRegs;
      logic [7:0] regs [4];
      regs = '{C1, C2, urx_pkg::DIVIDER_OFS, PW};
      foreach (regs[i]) rdchk(regs[i], 32'hff, 32'h0);
      rdchk(ST, 32'h2f, 32'h0);
      apb(1'b1, ST, 32'hff);
      rdchk(ST, 32'h2f, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      chk(rd, 32'h0);
   endtask
   task automatic testOverrun;
      apb(1'b1, C1, 32'h80);
      apb(1'b1, C2, 32'h44);
      apb(1'b1, PW, 32'h06);
      apb(1'b0, DA, 32'h0);
      c0 = irqs;
      send(8'ha5, 1'b1, -1);
      send(8'h3c, 1'b1, -1);
      send(8'h0f, 1'b1, -1);
      chk(32'(irqs - c0), 32'd3);
      rdchk(DA, 32'hff, 32'ha5);
      rdchk(DA, 32'hff, 32'ha5);
      rdchk(ST, 32'h28, 32'h28);
      rdchk(DA, 32'hff, 32'ha5);
      rdchk(ST, 32'h28, 32'h20);
      rdchk(DA, 32'hff, 32'h3c);
      rdchk(ST, 32'h20, 32'h0);
   endtask
   task automatic testErrors;
      send(8'h5a, 1'b0, -1);
      rdchk(ST, 32'h27, 32'h22);
      rdchk(DA, 32'hff, 32'h5a);
      apb(1'b1, C1, 32'ha0);
      line.send({1'b1, 1'b1, 1'b0, 8'h01, 1'b0}, 11, -1);
      repeat (30) @(posedge ref_clk);
      rdchk(ST, 32'h27, 32'h21);
      rdchk(DA, 32'hff, 32'h01);
      apb(1'b1, C1, 32'h80);
      c0 = irqs;
      send(8'h3c, 1'b1, 56);
      chk(32'(irqs - c0), 32'd1);
      rdchk(ST, 32'h27, 32'h24);
      rdchk(DA, 32'hff, 32'h3c);
      rdchk(ST, 32'h27, 32'h0);
   endtask
   task automatic testAddr;
      apb(1'b1, C1, 32'h80);
      apb(1'b1, C2, 32'h64);
      c0 = irqs;
      send(8'h12, 1'b1, -1);
      chk(32'(irqs - c0), 32'd0);
      clr;
      send(8'h92, 1'b1, -1);
      chk(32'(irqs - c0), 32'd1);
      clr;
   endtask
   task automatic testTx;
      apb(1'b1, C2, 32'h01);
      c0 = irqs;
      pulseTx(1'b0);
      chk(32'(irqs - c0), 32'd1);
      pulseTx(1'b1);
      chk(32'(irqs - c0), 32'd1);
      apb(1'b1, C2, 32'h03);
      txIdle <= 1'b0;
      pulseTx(1'b1);
      chk(32'(irqs - c0), 32'd2);
      apb(1'b1, PW, 32'h0);
      txEmpty <= 1'b0;
      pulseTx(1'b0);
      chk(32'(irqs - c0), 32'd2);
   endtask
   task automatic testWake(input logic [31:0] pw, input int n);
      apb(1'b1, C2, 32'h4c);
      rdchk(ST, 32'h30, 32'h10);
      apb(1'b1, PW, pw);
      c0 = irqs;
      wakes = 0;
      send(8'h55, 1'b1, -1);
      repeat (220) @(posedge ref_clk);
      chk(32'(wakes), 32'(STARTUP));
      chk(32'(irqs - c0), 32'(n));
      rdchk(ST, 32'h20, 32'h0);
      rdchk(PW, 32'hff, pw & 32'hfe);
      rdchk(C1, 32'hff, 32'h80);
      rdchk(C2, 32'hff, 32'h4c);
   endtask
   task automatic stopTest;
      $display("errors %0d comparisons %0d", numErrors, cmpCount);
      if (numErrors == 0 && cmpCount > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      testRegs;
      testOverrun;
      testErrors;
      testAddr;
      testTx;
      testWake(32'h07, 1);
      testWake(32'h01, 0);
      stopTest;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      numErrors++;
      stopTest;
   end
endmodule // urx_error_irq_tb
bind urx_error_irq urx_error_irq_assertions #(.STARTUP(STARTUP)) chk_i (.ref_clk(ref_clk), .reset_n(reset_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .rxLine(rxLine), .txEmpty(txEmpty), .txIdle(txIdle),
   .irqPulse_n(irqPulse_n), .wakeRequest(wakeRequest));
`default_nettype wire
